// ==== src/scsc_top.sv ====
/*
 holds the system clock and stand-by controller of an 8-bit core:
 timing generator, machine cycle sequencer, normal/idle/stop control.
 assumes one high-frequency clock; the cpu and peripherals use the
 enables here rather than gated clocks.
*/
// Functional notes
// - prescaler by three feeds a 21-stage divider, plus sequencer
// - reset and stop exit clear the divider; stop exit keeps the prescaler, reset clears it
// - clock divided by 256 enters the seventh divider stage; the code feeds fc/3 to the first stage instead
// - machine cycle is four states of one main clock each
// - instructions last one to fifteen machine cycles
// - one machine cycle is four high-frequency clocks
// - cpu and peripherals advance on the main clock enable
// - supplies main, base timer, watchdog, timer, warm-up, reset clocks
// - normal mode runs cpu and peripherals on the fast clock
// - idle keeps peripherals running, stops cpu and watchdog
// - writing the idle bit in control two enters idle
// - peripheral or external interrupt ends idle
// - with master enable set, interrupt is serviced first
// - with master enable clear, next instruction runs, no service
// - reset pin is input plus open output for internal resets
// - stop bit in control one stops everything
// - stop pin by level or edge releases stop after warm-up
`timescale 1ns/1ps
module scsc_top
#(
   parameter int STAGES = scsc_pkg::DIV_STAGES,
   parameter int RST_OUT_TAP = scsc_pkg::RST_OUT_TAP
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // system_control_one bits
   input wire logic stop_set_i,
   input wire logic stop_level_mode_i,
   input wire logic [1:0] warm_sel_i,
   input wire logic slow_warm_i,
   // system_control_two bits
   input wire logic idle_set_i,
   // interrupts and flags
   input wire logic irq_i,
   input wire logic interrupt_master_enable_flag_i,
   input wire logic stop_pin_i,
   // cpu instruction length
   input wire logic [3:0] instr_len_i,
   // internal reset sources
   input wire logic wdt_reset_i,
   input wire logic trap_reset_i,
   input wire logic sysclk_reset_i,
   // reset pin, open-drain
   input wire logic reset_pin_in_i,
   output logic reset_pin_out_o,
   output logic reset_pin_oe_o,
   output logic int_reset_o,
   // clock enables
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic wdt_clk_en_o,
   output logic [STAGES-1:0] div_tick_o,
   output logic warm_done_o,
   // machine cycle status
   output logic [1:0] cycle_state_o,
   output logic cycle_state_first_o,
   output logic cycle_state_last_o,
   output logic instr_end_o,
   // stand-by status
   output logic [1:0] mode_o,
   output logic idle_flag_o,
   output logic irq_service_o,
   output logic resume_next_o
);
   scsc_pkg::scsc_mode_t mode;
   scsc_pkg::scsc_mode_t next_mode;
   logic [STAGES-1:0] div;
   logic [STAGES-1:0] tick;
   logic osc_run;
   logic div_clear;
   logic seq_run;
   logic cycle_end;
   logic seq_end;
   logic [1:0] seq_state;
   logic stop_pin_q;
   logic stop_release;
   logic warm_hit;
   logic [1:0] warm_count;
   logic [1:0] warm_need;
   logic rst_hold;
   logic int_rst_req;

   // ------------------------------------------------------------
   // timing generator
   // ------------------------------------------------------------
   // oscillator off in stop; prescaler and divider both stand still then
   assign osc_run = (mode != scsc_pkg::SCSC_STOP);
   assign div_clear = (mode == scsc_pkg::SCSC_STOP) && stop_release;

   // stage 0 input is fc/3 from the prescaler, so stage 7 input is fc/384;
   // the taps follow a plain binary chain; tap index names the stage output
   scsc_divider #(
      .STAGES(STAGES)
   ) u_div (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .clear_i(div_clear),
      .run_i(osc_run),
      .div_o(div),
      .tick_o(tick)
   );

   // ------------------------------------------------------------
   // machine cycle sequencer
   // ------------------------------------------------------------
   // cpu side only advances in normal; peripherals keep the clock in idle too
   assign seq_run = (mode == scsc_pkg::SCSC_NORMAL);

   scsc_sequencer u_seq (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .run_i(seq_run),
      .instr_len_i(instr_len_i),
      .state_o(seq_state),
      .cycle_end_o(cycle_end),
      .instr_end_o(seq_end)
   );

   // ------------------------------------------------------------
   // stop release detection
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         stop_pin_q <= 1'b0;
      else
         stop_pin_q <= stop_pin_i;

   assign stop_release = stop_level_mode_i ? stop_pin_i
                         : (stop_pin_i && !stop_pin_q);

   // warm-up: 2^15 or 5 x 2^15 divider periods from the cleared divider (doubled when slow)
   assign warm_hit = tick[scsc_pkg::WARM_TAP - 1 + (slow_warm_i ? 1 : 0)];
   assign warm_need = (warm_sel_i == scsc_pkg::WARM_3X16) ? 2'h3 : 2'h1;

   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         warm_count <= 2'h0;
      else if (mode != scsc_pkg::SCSC_WARM)
         warm_count <= 2'h0;
      else if (warm_hit)
         warm_count <= warm_count + 2'h1;

   // ------------------------------------------------------------
   // stand-by mode control
   // ------------------------------------------------------------
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         scsc_pkg::SCSC_NORMAL:
         begin
            if (stop_set_i && seq_end)
               next_mode = scsc_pkg::SCSC_STOP;
            else if (idle_set_i && seq_end)
               next_mode = scsc_pkg::SCSC_IDLE;
         end
         scsc_pkg::SCSC_IDLE:
         begin
            if (irq_i)
               next_mode = scsc_pkg::SCSC_NORMAL;
         end
         scsc_pkg::SCSC_STOP:
         begin
            if (stop_release)
               next_mode = scsc_pkg::SCSC_WARM;
         end
         scsc_pkg::SCSC_WARM:
         begin
            if (warm_hit && (warm_count + 2'h1 >= warm_need))
               next_mode = scsc_pkg::SCSC_NORMAL;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         mode <= scsc_pkg::SCSC_NORMAL;
      else
         mode <= next_mode;

   // ------------------------------------------------------------
   // idle release outcome
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
      begin
         irq_service_o <= 1'b0;
         resume_next_o <= 1'b0;
         idle_flag_o <= 1'b0;
         warm_done_o <= 1'b0;
      end
      else
      begin
         irq_service_o <= (mode == scsc_pkg::SCSC_IDLE) && irq_i
                          && interrupt_master_enable_flag_i;
         resume_next_o <= (mode == scsc_pkg::SCSC_IDLE) && irq_i
                          && !interrupt_master_enable_flag_i;
         idle_flag_o <= (next_mode == scsc_pkg::SCSC_IDLE);
         warm_done_o <= (mode == scsc_pkg::SCSC_WARM)
                        && (next_mode == scsc_pkg::SCSC_NORMAL);
      end

   // ------------------------------------------------------------
   // reset pin: open output stretched by a divider tap
   // ------------------------------------------------------------
   assign int_rst_req = wdt_reset_i || trap_reset_i || sysclk_reset_i;

   // hold until the release-clock tap ticks, so the pulse is seen off-chip
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         rst_hold <= 1'b0;
      else if (int_rst_req)
         rst_hold <= 1'b1;
      else if (tick[RST_OUT_TAP])
         rst_hold <= 1'b0;

   assign reset_pin_out_o = 1'b0;
   assign reset_pin_oe_o = rst_hold;
   assign int_reset_o = rst_hold || !reset_pin_in_i;

   // ------------------------------------------------------------
   // clock enables and status
   // ------------------------------------------------------------
   assign cpu_clk_en_o = seq_run;
   assign periph_clk_en_o = (mode == scsc_pkg::SCSC_NORMAL)
                            || (mode == scsc_pkg::SCSC_IDLE);
   assign wdt_clk_en_o = seq_run;
   assign div_tick_o = tick;
   assign cycle_state_o = seq_state;
   assign cycle_state_first_o = seq_run && (seq_state == 2'h0);
   assign cycle_state_last_o = cycle_end;
   assign instr_end_o = seq_end;
   assign mode_o = mode;
endmodule

// ==== src/scsc_pkg.sv ====
/*
 holds the constants shared by the clock controller and its helpers.
 assumes nothing of its surroundings; imported by name only.
*/
package scsc_pkg;
   // ------------------------------------------------------------
   // divider structure
   // ------------------------------------------------------------
   localparam int PRESCALE_DIV = 3;
   localparam int DIV_STAGES = 21;
   localparam int DIV_ENTRY_STAGE = 7;
   localparam int PRE_W = 2;
   localparam logic [PRE_W-1:0] PRE_LAST = 2'h2;
   localparam logic [PRE_W-1:0] PRE_RESET = 2'h0;
   localparam logic [20:0] DIV_RESET = 21'h000000;
   // ------------------------------------------------------------
   // machine cycle
   // ------------------------------------------------------------
   localparam int STATES_PER_CYCLE = 4;
   localparam int MAX_INSTR_CYCLES = 15;
   localparam logic [3:0] CYC_RESET = 4'h1;
   // ------------------------------------------------------------
   // stop warm-up and reset output
   // ------------------------------------------------------------
   localparam logic [1:0] WARM_3X16 = 2'h0;
   localparam logic [1:0] WARM_1X16 = 2'h1;
   localparam int WARM_TAP = 16;
   localparam int RST_OUT_TAP = 10;
   typedef enum logic [1:0]
   {
      SCSC_NORMAL = 2'b00,
      SCSC_IDLE = 2'b01,
      SCSC_STOP = 2'b10,
      SCSC_WARM = 2'b11
   } scsc_mode_t;
endpackage

// ==== src/scsc_divider.sv ====
/*
 holds the divide-by-3 prescaler and the binary ripple-free divider chain.
 assumes a synchronous clear from the controller on leaving stop.
*/
`timescale 1ns/1ps
module scsc_divider
#(
   parameter int STAGES = scsc_pkg::DIV_STAGES
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // control
   input wire logic clear_i,
   input wire logic run_i,
   // taps
   output logic [STAGES-1:0] div_o,
   output logic [STAGES-1:0] tick_o
);
   logic [scsc_pkg::PRE_W-1:0] pre;
   logic pre_tick;
   logic [STAGES-1:0] next_div;

   // ------------------------------------------------------------
   // prescaler: left running on stop exit, reset only clears it
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         pre <= scsc_pkg::PRE_RESET;
      else if (run_i)
         pre <= (pre == scsc_pkg::PRE_LAST) ? scsc_pkg::PRE_RESET
                : pre + 2'h1;

   assign pre_tick = run_i && (pre == scsc_pkg::PRE_LAST);

   // ------------------------------------------------------------
   // divider chain
   // ------------------------------------------------------------
   assign next_div = div_o + {{(STAGES-1){1'b0}}, pre_tick};

   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         div_o <= '0;
      else if (clear_i)
         div_o <= '0;
      else
         div_o <= next_div;

   // one-cycle rising event per stage output
   genvar g;
   generate
      for (g = 0; g < STAGES; g++)
      begin : gen_tick
         assign tick_o[g] = next_div[g] && !div_o[g] && pre_tick;
      end
   endgenerate
endmodule

// ==== src/scsc_sequencer.sv ====
/*
 holds the machine cycle sequencer: four states per machine cycle and
 an instruction-length counter of up to fifteen cycles.
 assumes the cpu presents the length of each new instruction.
*/
`timescale 1ns/1ps
module scsc_sequencer
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [3:0] instr_len_i,
   // status
   output logic [1:0] state_o,
   output logic cycle_end_o,
   output logic instr_end_o
);
   logic [3:0] cyc;

   assign cycle_end_o = run_i && (state_o == 2'h3);
   assign instr_end_o = cycle_end_o && (cyc <= 4'h1);

   // ------------------------------------------------------------
   // states: one main clock each
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         state_o <= 2'h0;
      else if (run_i)
         state_o <= state_o + 2'h1;

   // ------------------------------------------------------------
   // cycles left in this instruction
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         cyc <= scsc_pkg::CYC_RESET;
      else if (instr_end_o)
         cyc <= (instr_len_i == 4'h0) ? 4'h1 : instr_len_i;
      else if (cycle_end_o)
         cyc <= cyc - 4'h1;
endmodule

// ==== tb/scsc_asserts.sv ====
/*
 checker of sequencer and stand-by relations at the scsc_top ports.
 assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module scsc_asserts
#(
   parameter int STAGES = 21
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // requests
   input wire logic stop_set_i,
   input wire logic idle_set_i,
   input wire logic irq_i,
   input wire logic interrupt_master_enable_flag_i,
   input wire logic reset_pin_in_i,
   // status
   input wire logic int_reset_o,
   input wire logic cpu_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic [STAGES-1:0] div_tick_o,
   input wire logic [1:0] cycle_state_o,
   input wire logic cycle_state_last_o,
   input wire logic instr_end_o,
   input wire logic [1:0] mode_o,
   input wire logic irq_service_o,
   input wire logic resume_next_o
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wake;
      mode_o == 2'h1 && irq_i;
   endsequence
   sequence s_back;
      mode_o == 2'h0
      && irq_service_o == $past(interrupt_master_enable_flag_i)
      && resume_next_o != $past(interrupt_master_enable_flag_i);
   endsequence
   AST_STATE_STEP:
      assert property (!rst_i && mode_o == 2'h0 |=> mode_o != 2'h0
         || cycle_state_o == $past(cycle_state_o) + 2'h1)
      else $error("state did not advance");
   AST_LAST_STATE:
      assert property (cycle_state_last_o == (cycle_state_o == 2'h3))
      else $error("last state flag wrong");
   AST_END_AT_LAST:
      assert property (instr_end_o |-> cycle_state_last_o)
      else $error("instruction ended off the last state");
   AST_IDLE_ENTER:
      assert property (mode_o == 2'h0 && instr_end_o && idle_set_i
         && !stop_set_i && !irq_i |=> mode_o == 2'h1)
      else $error("idle not entered");
   AST_IDLE_EXIT:
      assert property (s_wake |=> s_back)
      else $error("idle wake-up wrong");
   AST_IDLE_CLOCKS:
      assert property (mode_o == 2'h1 |-> !cpu_clk_en_o && periph_clk_en_o)
      else $error("idle enables wrong");
   AST_STOP_ENTER:
      assert property (mode_o == 2'h0 && instr_end_o && stop_set_i
         |=> mode_o == 2'h2 && !cpu_clk_en_o && !periph_clk_en_o)
      else $error("stop not entered");
   AST_PIN_RESET:
      assert property (!reset_pin_in_i |-> int_reset_o)
      else $error("pin reset not passed on");
   // prescaler by three: divider bit 0 rises every six clocks
   AST_DIV_TICK:
      assert property (div_tick_o[0] ##1 (mode_o != 2'h2) [*6]
         |-> div_tick_o[0])
      else $error("divider tick period wrong");
endmodule
bind scsc_top scsc_asserts #(.STAGES(STAGES)) u_asserts
(
   .core_clk_i(core_clk_i), .rst_i(rst_i), .stop_set_i(stop_set_i),
   .idle_set_i(idle_set_i), .irq_i(irq_i),
   .interrupt_master_enable_flag_i(interrupt_master_enable_flag_i),
   .reset_pin_in_i(reset_pin_in_i), .int_reset_o(int_reset_o),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .div_tick_o(div_tick_o), .cycle_state_o(cycle_state_o),
   .cycle_state_last_o(cycle_state_last_o), .instr_end_o(instr_end_o),
   .mode_o(mode_o), .irq_service_o(irq_service_o),
   .resume_next_o(resume_next_o)
);

// ==== tb/scsc_cpu_model.sv ====
/*
 cpu and peripheral stand-in: idle bit, interrupt, instruction length.
 assumes the bench sets the wants at rising edges.
*/
`timescale 1ns/1ps
module scsc_cpu_model
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // bench commands
   input wire logic want_idle_i,
   input wire logic want_irq_i,
   input wire logic [3:0] len_i,
   // device status
   input wire logic [1:0] mode_i,
   // to the device
   output logic idle_set_o,
   output logic irq_o,
   output logic [3:0] instr_len_o
);
   // ----------
   // software behaviour
   // ----------
   // the idle bit drops once halted; the request holds until woken
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idle_set_o <= 1'h0;
         irq_o <= 1'h0;
         instr_len_o <= 4'h1;
      end
      else
      begin
         idle_set_o <= want_idle_i && mode_i != 2'h1;
         irq_o <= want_irq_i || (irq_o && mode_i != 2'h0);
         instr_len_o <= len_i;
      end
   end
endmodule

// ==== tb/scsc_tb_top.sv ====
/*
 self-checking bench: reset, sequencer, idle, reset pin, stop.
 assumes scsc_cpu_model as the cpu side; pin has a pull-up.
*/
`timescale 1ns/1ps
module scsc_tb_top;
   // ----------
   // signals
   // ----------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic stop_set = 1'h0;
   logic stop_lvl = 1'h1;
   logic stop_pin = 1'h0;
   logic flag = 1'h0;
   logic ext_low = 1'h0;
   logic want_idle = 1'h0;
   logic want_irq = 1'h0;
   logic [2:0] rsrc = 3'h0;
   logic [3:0] len = 4'h1;
   logic idle_set, irq, oe, pout, int_rst, cpu_en, per_en, wdt_en, pin;
   logic iend, first, last, idle_flag, svc, resume;
   logic [3:0] ilen;
   logic [1:0] state, mode;
   logic [20:0] tick;
   int bad_count = 0;
   int compares = 0;
   int ticks = 0;
   assign pin = !(ext_low || (oe && !pout));
   scsc_cpu_model cpu (.core_clk_i(clk), .rst_i(rst),
      .want_idle_i(want_idle), .want_irq_i(want_irq), .len_i(len),
      .mode_i(mode), .idle_set_o(idle_set), .irq_o(irq),
      .instr_len_o(ilen));
   // short reset-release tap keeps the run brief
   scsc_top #(.RST_OUT_TAP(3)) dut (.core_clk_i(clk), .rst_i(rst),
      .stop_set_i(stop_set), .stop_level_mode_i(stop_lvl), .warm_sel_i(2'h1),
      .slow_warm_i(1'h0), .idle_set_i(idle_set), .irq_i(irq),
      .interrupt_master_enable_flag_i(flag), .stop_pin_i(stop_pin),
      .instr_len_i(ilen), .wdt_reset_i(rsrc[0]), .trap_reset_i(rsrc[1]),
      .sysclk_reset_i(rsrc[2]), .reset_pin_in_i(pin),
      .reset_pin_out_o(pout), .reset_pin_oe_o(oe), .int_reset_o(int_rst),
      .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
      .wdt_clk_en_o(wdt_en), .div_tick_o(tick), .warm_done_o(),
      .cycle_state_o(state), .cycle_state_first_o(first),
      .cycle_state_last_o(last), .instr_end_o(iend), .mode_o(mode),
      .idle_flag_o(idle_flag), .irq_service_o(svc),
      .resume_next_o(resume));
   // ----------
   // helpers
   // ----------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic w_mode(input logic [1:0] m);
      int i;
      #1;
      for (i = 0; i < 200 && mode !== m; i++)
         cyc(1);
   endtask
   task automatic w_end(output int n);
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end
      while (iend !== 1'h1 && n < 100);
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_reset();
      chk({mode, cpu_en, per_en, wdt_en, oe}, 8'he);
      @(posedge clk);
      ext_low <= 1'h1;
      cyc(1);
      chk(int_rst, 8'h1);
      @(posedge clk);
      ext_low <= 1'h0;
   endtask
   task automatic t_len();
      int n;
      int k;
      logic [3:0] l [4] = '{4'h0, 4'h1, 4'hf, 4'h2};
      for (k = 0; k < 4; k++)
      begin
         @(posedge clk);
         len <= l[k];
         w_end(n);
         w_end(n);
         chk({first, last}, 8'h1);
         chk(n, (l[k] == 4'h0) ? 8'h4 : {2'h0, l[k], 2'h0});
      end
   endtask
   task automatic t_idle(input logic f);
      @(posedge clk);
      flag <= f;
      want_idle <= 1'h1;
      w_mode(2'h1);
      @(posedge clk);
      want_idle <= 1'h0;
      cyc(5);
      chk({mode, cpu_en, per_en, wdt_en, idle_flag}, 8'h15);
      @(posedge clk);
      want_irq <= 1'h1;
      @(posedge clk);
      want_irq <= 1'h0;
      w_mode(2'h0);
      chk({svc, resume, idle_flag, cpu_en}, {4'h0, f, !f, 2'h1});
      cyc(8);
      chk(mode, 8'h0);
   endtask
   task automatic t_rout();
      int k;
      int i;
      for (k = 0; k < 3; k++)
      begin
         @(posedge clk);
         rsrc <= 3'h1 << k;
         @(posedge clk);
         rsrc <= 3'h0;
         cyc(0);
         chk({oe, int_rst}, 8'h3);
         for (i = 0; i < 200 && oe !== 1'h0; i++)
            cyc(1);
         chk({oe, int_rst}, 8'h0);
      end
   endtask
   task automatic t_stop();
      int k;
      int j;
      // edge release first, then level release
      for (j = 0; j < 2; j++)
      begin
         @(posedge clk);
         stop_lvl <= (j == 1);
         stop_set <= 1'h1;
         w_mode(2'h2);
         @(posedge clk);
         stop_set <= 1'h0;
         for (k = 0; k < 8; k++)
         begin
            cyc(1);
            chk({cpu_en, per_en, wdt_en, |tick, mode}, 8'h2);
         end
         @(posedge clk);
         stop_pin <= 1'h1;
         w_mode(2'h3);
         chk({mode, cpu_en, per_en}, 8'hc);
         @(posedge clk);
         stop_pin <= 1'h0;
         // warm-up is far too long to run out here; reset ends it
         @(posedge clk);
         rst <= 1'h1;
         @(posedge clk);
         rst <= 1'h0;
         cyc(1);
         chk({mode, cpu_en}, 8'h1);
      end
   endtask
   // ----------
   // run control
   // ----------
   task automatic close_out();
      $display("compares %0d errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      forever #5 clk = !clk;
   end
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 5000)
      begin
         bad_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      cyc(1);
      t_reset();
      t_len();
      t_idle(1'h1);
      t_idle(1'h0);
      t_rout();
      t_stop();
      close_out();
   end
endmodule
